// file: src/tte_defs.svh
// constants for the thermal trip event logic
`ifndef TTE_DEFS_SVH
`define TTE_DEFS_SVH
// temperature field width in quarter-degree steps
`define TTE_TEMP_W 11
// configuration word bit positions
`define TTE_CFG_MODE 0
`define TTE_CFG_POL 1
`define TTE_CFG_CRIT_ONLY 2
`define TTE_CFG_OUT_EN 3
`define TTE_CFG_STATUS 4
`define TTE_CFG_CLR 5
`define TTE_CFG_ALM_LOCK 6
`define TTE_CFG_CRIT_LOCK 7
`define TTE_CFG_SHDN 8
`define TTE_CFG_HYS_LO 9
`define TTE_CFG_HYS_HI 10
`define TTE_CFG_W 16
// temperature word layout
`define TTE_FLAG_CRIT 15
`define TTE_FLAG_ABOVE 14
`define TTE_FLAG_BELOW 13
`define TTE_TEMP_MSB 12
`define TTE_TEMP_LSB 2
`define TTE_WORD_W 16
`define TTE_BYTE_W 8
`define TTE_FINE_BITS 2'h0
// hysteresis field codes and their size in quarter degrees
`define TTE_HYS_OFF 2'h0
`define TTE_HYS_1P5 2'h1
`define TTE_HYS_3 2'h2
`define TTE_HYS_6 2'h3
`define TTE_HYS_Q_W 5
`define TTE_HYS_Q_OFF 5'h00
`define TTE_HYS_Q_1P5 5'h06
`define TTE_HYS_Q_3 5'h0c
`define TTE_HYS_Q_6 5'h18
`endif

// file: src/tte_pkg.sv
// state types of the thermal trip event logic
`include "tte_defs.svh"
package tte_pkg;
   typedef struct packed {
      logic above;
      logic below;
      logic crit;
      logic zone;
      logic [`TTE_TEMP_W-1:0] temp;
   } tte_trip_state_type;

   typedef struct packed {
      logic pull_low;
   } tte_drv_state_type;

   typedef struct packed {
      logic mode;
      logic pol;
      logic crit_only;
      logic out_en;
      logic alm_lock;
      logic crit_lock;
      logic shdn;
      logic [1:0] hys;
      logic irq_latch;
      logic above_q;
      logic below_q;
      logic rd_ptr;
      logic [`TTE_BYTE_W-1:0] rd_snap;
      logic [`TTE_BYTE_W-1:0] rd_byte;
      logic [`TTE_WORD_W-1:0] word;
      logic [`TTE_CFG_W-1:0] cfg_rd;
   } tte_core_state_type;
endpackage : tte_pkg

// file: src/tte_trip_cmp.sv
// threshold comparison with hysteresis and the three trip flags
`timescale 1ns/1ps
`include "tte_defs.svh"
module tte_trip_cmp import tte_pkg::*; #(
   parameter int TEMP_W = `TTE_TEMP_W
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic sample_valid_in,
   input wire logic hold_in,
   input wire logic [TEMP_W-1:0] sample_in,
   input wire logic [TEMP_W-1:0] upper_in,
   input wire logic [TEMP_W-1:0] lower_in,
   input wire logic [TEMP_W-1:0] limit_in,
   input wire logic [`TTE_HYS_Q_W-1:0] hys_q_in,
   output logic above_out,
   output logic below_out,
   output logic crit_out,
   output logic zone_out,
   output logic [TEMP_W-1:0] temp_out
);
   tte_trip_state_type st_ff;
   tte_trip_state_type nxt_st;
   logic signed [TEMP_W:0] t_s;
   logic signed [TEMP_W:0] up_s;
   logic signed [TEMP_W:0] lo_s;
   logic signed [TEMP_W:0] cr_s;
   logic signed [TEMP_W:0] hy_s;

   if (TEMP_W != `TTE_TEMP_W) begin : g_chk
      $error("tte_trip_cmp: TEMP_W must match the state type");
   end

   // one extra bit keeps threshold minus hysteresis from wrapping
   assign t_s = {sample_in[TEMP_W-1], sample_in};
   assign up_s = {upper_in[TEMP_W-1], upper_in};
   assign lo_s = {lower_in[TEMP_W-1], lower_in};
   assign cr_s = {limit_in[TEMP_W-1], limit_in};
   assign hy_s = (TEMP_W+1)'(hys_q_in);

   always_comb begin
      nxt_st = st_ff;
      if (sample_valid_in && !hold_in) begin // [R14]
         nxt_st.temp = sample_in;
         if (t_s > up_s) begin // [R3]
            nxt_st.above = 1'b1;
         end else if (t_s <= up_s - hy_s) begin // [R4]
            nxt_st.above = 1'b0;
         end
         if (t_s < lo_s - hy_s) begin // [R5]
            nxt_st.below = 1'b1;
         end else if (t_s >= lo_s) begin // [R6]
            nxt_st.below = 1'b0;
         end
         nxt_st.crit = (t_s >= cr_s); // [R7]
         // critical region for the alert pin releases only below limit minus hysteresis
         if (t_s >= cr_s) begin // [R10]
            nxt_st.zone = 1'b1;
         end else if (t_s < cr_s - hy_s) begin // [R15]
            nxt_st.zone = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign above_out = st_ff.above;
   assign below_out = st_ff.below;
   assign crit_out = st_ff.crit;
   assign zone_out = st_ff.zone;
   assign temp_out = st_ff.temp;
endmodule : tte_trip_cmp

// file: src/tte_alert_drv.sv
// open-drain alert pin driver with polarity
`timescale 1ns/1ps
module tte_alert_drv import tte_pkg::*; (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic active_in,
   input wire logic active_high_in,
   output logic alert_out,
   output logic alert_oe_out
);
   tte_drv_state_type st_ff;
   tte_drv_state_type nxt_st;

   // pin is pulled low for an active-low alert, or for an idle active-high alert
   always_comb begin
      nxt_st = st_ff;
      nxt_st.pull_low = active_in ^ active_high_in; // [R12]
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // only the low level is ever driven; the pull-up makes the high level
   assign alert_out = 1'b0; // [R13]
   assign alert_oe_out = st_ff.pull_low; // [R13]
endmodule : tte_alert_drv

// file: src/tte_core.sv
// thermal trip detection, configuration word and alert control
`timescale 1ns/1ps
`include "tte_defs.svh"
// Function
// R1 - clear-alert write ignored in comparator style; bit always reads zero.
// R2 - host writes one to clear-alert to release a latched interrupt alert.
// R3 - above-window flag sets when temperature exceeds the upper boundary.
// R4 - above-window flag clears only at or below upper minus hysteresis.
// R5 - below-window flag sets below lower boundary minus hysteresis.
// R6 - below-window flag clears at or above the lower boundary.
// R7 - critical flag follows temperature at or above the overheat limit.
// R8 - both window flags zero means temperature lies inside the window.
// R9 - trip flags depend only on comparisons, not alert or configuration.
// R10 - hysteresis also shapes alert pin release points.
// R11 - hysteresis field cannot change while either lock bit is set.
// R12 - enable and style bits pick alert style; polarity bit picks level.
// R13 - alert pin is open drain, only ever pulled low.
// R14 - shutdown freezes alert and trip state as they were.
// R15 - interrupt style: critical alert holds until below limit minus hysteresis.
// R16 - in the critical region the alert acts as comparator style.
// R17 - comparator style asserts while outside window or critical, with hysteresis.
// R18 - temperature word is read-only, high byte first then low byte.
// R19 - two's complement, quarter-degree step, finer bits forced to zero.
// R20 - top temperature bit weighs 128 degrees and is the sign, bit 12; here bit 12 is the sign weighing -256 degrees and bit 11 weighs 128.
// R21 - alert stays inactive whenever the output enable bit is zero.
// R22 - hysteresis codes: off, 1.5, 3 and 6 degrees.
module tte_core import tte_pkg::*; #(
   parameter int TEMP_W = `TTE_TEMP_W
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic sensing_core_valid_in,
   input wire logic [TEMP_W-1:0] sensing_core_temp_in,
   input wire logic [`TTE_WORD_W-1:0] upper_limit_in,
   input wire logic [`TTE_WORD_W-1:0] lower_limit_in,
   input wire logic [`TTE_WORD_W-1:0] overheat_limit_in,
   input wire logic cfg_wr_in,
   input wire logic [`TTE_CFG_W-1:0] cfg_wdata_in,
   output logic [`TTE_CFG_W-1:0] cfg_rdata_out,
   input wire logic temp_rd_start_in,
   input wire logic temp_rd_in,
   output logic [`TTE_BYTE_W-1:0] temp_byte_out,
   output logic [`TTE_WORD_W-1:0] temp_word_out,
   output logic alert_out,
   output logic alert_oe_out
);
   tte_core_state_type st_ff;
   tte_core_state_type nxt_st;
   logic above;
   logic below;
   logic crit;
   logic zone;
   logic [TEMP_W-1:0] temp;
   logic [`TTE_HYS_Q_W-1:0] hys_q;
   logic [`TTE_WORD_W-1:0] word_now;
   logic locked;
   logic clr_req;
   logic trig;
   logic cond;
   logic active;

   if (TEMP_W != `TTE_TEMP_W || TEMP_W != `TTE_TEMP_MSB - `TTE_TEMP_LSB + 1) begin : g_chk
      $error("tte_core: TEMP_W must fill the temperature field");
   end

   always_comb begin
      unique case (st_ff.hys) // [R22]
         `TTE_HYS_OFF: hys_q = `TTE_HYS_Q_OFF;
         `TTE_HYS_1P5: hys_q = `TTE_HYS_Q_1P5;
         `TTE_HYS_3: hys_q = `TTE_HYS_Q_3;
         `TTE_HYS_6: hys_q = `TTE_HYS_Q_6;
      endcase
   end

   tte_trip_cmp #(
      .TEMP_W(TEMP_W)
   ) u_trip (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .sample_valid_in(sensing_core_valid_in),
      .hold_in(st_ff.shdn),
      .sample_in(sensing_core_temp_in),
      .upper_in(upper_limit_in[`TTE_TEMP_MSB:`TTE_TEMP_LSB]),
      .lower_in(lower_limit_in[`TTE_TEMP_MSB:`TTE_TEMP_LSB]),
      .limit_in(overheat_limit_in[`TTE_TEMP_MSB:`TTE_TEMP_LSB]),
      .hys_q_in(hys_q),
      .above_out(above),
      .below_out(below),
      .crit_out(crit),
      .zone_out(zone),
      .temp_out(temp)
   );

   // flags come straight from the comparator, never from alert or config state
   assign word_now = {crit, above, below, temp, `TTE_FINE_BITS}; // [R9] [R19] [R20]
   assign locked = st_ff.alm_lock | st_ff.crit_lock;
   assign clr_req = cfg_wr_in && cfg_wdata_in[`TTE_CFG_CLR] && st_ff.mode; // [R1] [R2]
   assign trig = !st_ff.crit_only && ((above && !st_ff.above_q) || (below && !st_ff.below_q));
   assign cond = zone | (!st_ff.crit_only & (above | below)); // [R17] [R8]
   // critical region overrides interrupt style with comparator behaviour
   assign active = st_ff.out_en & (zone | (st_ff.mode ? st_ff.irq_latch : cond)); // [R16] [R21] [R12]

   always_comb begin
      nxt_st = st_ff;
      nxt_st.above_q = above;
      nxt_st.below_q = below;
      if (cfg_wr_in) begin
         nxt_st.alm_lock = st_ff.alm_lock | cfg_wdata_in[`TTE_CFG_ALM_LOCK];
         nxt_st.crit_lock = st_ff.crit_lock | cfg_wdata_in[`TTE_CFG_CRIT_LOCK];
         if (!locked) begin
            nxt_st.mode = cfg_wdata_in[`TTE_CFG_MODE];
            nxt_st.pol = cfg_wdata_in[`TTE_CFG_POL];
            nxt_st.out_en = cfg_wdata_in[`TTE_CFG_OUT_EN];
            nxt_st.hys = cfg_wdata_in[`TTE_CFG_HYS_HI:`TTE_CFG_HYS_LO]; // [R11]
         end
         if (!st_ff.alm_lock) begin
            nxt_st.crit_only = cfg_wdata_in[`TTE_CFG_CRIT_ONLY];
         end
         // shutdown can always be left but only entered while unlocked
         if (!cfg_wdata_in[`TTE_CFG_SHDN] || !locked) begin
            nxt_st.shdn = cfg_wdata_in[`TTE_CFG_SHDN];
         end
      end
      // a new trip in the clearing cycle still latches
      if (!st_ff.mode) begin
         nxt_st.irq_latch = 1'b0; // [R1]
      end else begin
         nxt_st.irq_latch = trig | (st_ff.irq_latch & !clr_req); // [R2]
      end
      if (temp_rd_start_in) begin
         nxt_st.rd_ptr = 1'b0;
      end
      // snapshot the low byte so the two halves belong to one sample
      if (temp_rd_in) begin
         if (temp_rd_start_in || !st_ff.rd_ptr) begin
            nxt_st.rd_byte = word_now[`TTE_WORD_W-1:`TTE_BYTE_W]; // [R18]
            nxt_st.rd_snap = word_now[`TTE_BYTE_W-1:0];
            nxt_st.rd_ptr = 1'b1;
         end else begin
            nxt_st.rd_byte = st_ff.rd_snap; // [R18]
            nxt_st.rd_ptr = 1'b0;
         end
      end
      nxt_st.word = word_now;
      nxt_st.cfg_rd = '0;
      nxt_st.cfg_rd[`TTE_CFG_MODE] = nxt_st.mode;
      nxt_st.cfg_rd[`TTE_CFG_POL] = nxt_st.pol;
      nxt_st.cfg_rd[`TTE_CFG_CRIT_ONLY] = nxt_st.crit_only;
      nxt_st.cfg_rd[`TTE_CFG_OUT_EN] = nxt_st.out_en;
      nxt_st.cfg_rd[`TTE_CFG_STATUS] = active;
      nxt_st.cfg_rd[`TTE_CFG_CLR] = 1'b0; // [R1]
      nxt_st.cfg_rd[`TTE_CFG_ALM_LOCK] = nxt_st.alm_lock;
      nxt_st.cfg_rd[`TTE_CFG_CRIT_LOCK] = nxt_st.crit_lock;
      nxt_st.cfg_rd[`TTE_CFG_SHDN] = nxt_st.shdn;
      nxt_st.cfg_rd[`TTE_CFG_HYS_HI:`TTE_CFG_HYS_LO] = nxt_st.hys;
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   tte_alert_drv u_drv (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .active_in(active),
      .active_high_in(st_ff.pol),
      .alert_out(alert_out),
      .alert_oe_out(alert_oe_out)
   );

   assign cfg_rdata_out = st_ff.cfg_rd;
   assign temp_byte_out = st_ff.rd_byte;
   assign temp_word_out = st_ff.word;

   // helper copies of the comparison operands for the checks below
   logic signed [TEMP_W:0] chk_t;
   logic signed [TEMP_W:0] chk_up;
   logic signed [TEMP_W:0] chk_lo;
   logic signed [TEMP_W:0] chk_cr;
   logic signed [TEMP_W:0] chk_hy;
   logic chk_upd;
   assign chk_t = {sensing_core_temp_in[TEMP_W-1], sensing_core_temp_in};
   assign chk_up = {upper_limit_in[`TTE_TEMP_MSB], upper_limit_in[`TTE_TEMP_MSB:`TTE_TEMP_LSB]};
   assign chk_lo = {lower_limit_in[`TTE_TEMP_MSB], lower_limit_in[`TTE_TEMP_MSB:`TTE_TEMP_LSB]};
   assign chk_cr = {overheat_limit_in[`TTE_TEMP_MSB], overheat_limit_in[`TTE_TEMP_MSB:`TTE_TEMP_LSB]};
   assign chk_hy = (TEMP_W+1)'(hys_q);
   assign chk_upd = sensing_core_valid_in && !st_ff.shdn;

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   property p_clr_reads_zero;
      cfg_wr_in && cfg_wdata_in[`TTE_CFG_CLR] |=> !cfg_rdata_out[`TTE_CFG_CLR] ##1 !cfg_rdata_out[`TTE_CFG_CLR];
   endproperty
   a_clr_reads_zero: assert property (p_clr_reads_zero) // [R1]
      else $error("clear-alert bit read back as one");

   property p_clr_ignored_cmp;
      !st_ff.mode && !(cfg_wr_in && !locked) |=> !st_ff.irq_latch;
   endproperty
   a_clr_ignored_cmp: assert property (p_clr_ignored_cmp) // [R1]
      else $error("interrupt latch held in comparator style");

   property p_above_set;
      chk_upd && chk_t > chk_up |=> above;
   endproperty
   a_above_set: assert property (p_above_set) // [R3]
      else $error("above-window flag not set over the upper boundary");

   property p_above_hold;
      above && chk_upd && chk_t > chk_up - chk_hy |=> above;
   endproperty
   a_above_hold: assert property (p_above_hold) // [R4]
      else $error("above-window flag released inside the hysteresis band");

   property p_below_set;
      chk_upd && chk_t < chk_lo - chk_hy |=> below;
   endproperty
   a_below_set: assert property (p_below_set) // [R5]
      else $error("below-window flag not set under lower minus hysteresis");

   property p_below_clr;
      chk_upd && chk_t >= chk_lo |=> !below ##1 (below == $past(below) || $past(sensing_core_valid_in));
   endproperty
   a_below_clr: assert property (p_below_clr) // [R6]
      else $error("below-window flag set at or above the lower boundary");

   property p_crit_flag;
      chk_upd |=> crit == $past(chk_t >= chk_cr);
   endproperty
   a_crit_flag: assert property (p_crit_flag) // [R7]
      else $error("critical flag disagrees with the overheat limit");

   property p_in_window;
      chk_upd && chk_t <= chk_up - chk_hy && chk_t >= chk_lo |=> !above && !below;
   endproperty
   a_in_window: assert property (p_in_window) // [R8]
      else $error("window flags set while inside the window");

   property p_flags_indep;
      !sensing_core_valid_in |=> $stable({crit, above, below});
   endproperty
   a_flags_indep: assert property (p_flags_indep) // [R9]
      else $error("trip flags moved without a new sample");

   property p_lock_hys;
      locked && cfg_wr_in |=> $stable(st_ff.hys) ##1 $stable(st_ff.hys) || cfg_wr_in;
   endproperty
   a_lock_hys: assert property (p_lock_hys) // [R11]
      else $error("hysteresis changed while locked");

   property p_shdn_hold;
      st_ff.shdn |=> $stable({crit, above, below, zone, temp});
   endproperty
   a_shdn_hold: assert property (p_shdn_hold) // [R14]
      else $error("trip state moved in shutdown");

   property p_en_off;
      !st_ff.out_en |=> alert_oe_out == $past(st_ff.pol);
   endproperty
   a_en_off: assert property (p_en_off) // [R21]
      else $error("alert active with output disabled");

   property p_crit_zone;
      st_ff.out_en && zone |=> alert_oe_out == !$past(st_ff.pol);
   endproperty
   a_crit_zone: assert property (p_crit_zone) // [R16]
      else $error("alert not asserted in the critical region");

   property p_cmp_style;
      st_ff.out_en && !st_ff.mode && !st_ff.crit_only && (above || below) |=> alert_oe_out == !$past(st_ff.pol);
   endproperty
   a_cmp_style: assert property (p_cmp_style) // [R17]
      else $error("comparator alert not asserted outside the window");

   property p_byte_order;
      temp_rd_start_in && temp_rd_in ##1 temp_rd_in && !temp_rd_start_in
         |-> temp_byte_out == $past(word_now[`TTE_WORD_W-1:`TTE_BYTE_W])
         ##1 temp_byte_out == $past(word_now[`TTE_BYTE_W-1:0], 2);
   endproperty
   a_byte_order: assert property (p_byte_order) // [R18]
      else $error("temperature bytes out of order");

   property p_zone_hold;
      zone && chk_upd && chk_t >= chk_cr - chk_hy |=> zone;
   endproperty
   a_zone_hold: assert property (p_zone_hold) // [R15]
      else $error("critical region released inside the hysteresis band");

   property p_zone_clr;
      chk_upd && chk_t < chk_cr - chk_hy |=> !zone;
   endproperty
   a_zone_clr: assert property (p_zone_clr) // [R10]
      else $error("critical region held below limit minus hysteresis");

   property p_irq_drive;
      st_ff.out_en && st_ff.mode && st_ff.irq_latch |=> alert_oe_out == !$past(st_ff.pol);
   endproperty
   a_irq_drive: assert property (p_irq_drive) // [R12]
      else $error("latched interrupt alert not driven");

   property p_cmp_idle;
      st_ff.out_en && !st_ff.mode && !zone && !above && !below |=> alert_oe_out == $past(st_ff.pol);
   endproperty
   a_cmp_idle: assert property (p_cmp_idle) // [R17]
      else $error("comparator alert asserted inside the window");

   property p_word_temp;
      chk_upd |-> ##2 temp_word_out[`TTE_TEMP_MSB:`TTE_TEMP_LSB] == $past(sensing_core_temp_in, 2)
         && temp_word_out[`TTE_TEMP_LSB-1:0] == `TTE_FINE_BITS;
   endproperty
   a_word_temp: assert property (p_word_temp) // [R19] [R20]
      else $error("temperature word disagrees with the accepted sample");
endmodule : tte_core

// file: bench/tte_host_model.sv
// host-side model: configuration writes, temperature word reads and the pulled-up alert wire
`timescale 1ns/1ps
`include "tte_defs.svh"
module tte_host_model (
   input wire logic sys_clk_in,
   input wire logic [`TTE_BYTE_W-1:0] temp_byte_in,
   input wire logic alert_oe_in,
   output logic cfg_wr_out,
   output logic [`TTE_CFG_W-1:0] cfg_wdata_out,
   output logic temp_rd_start_out,
   output logic temp_rd_out,
   output logic alert_pin_out
);
   // board pull-up holds the wire high unless the device sinks it
   assign alert_pin_out = alert_oe_in ? 1'b0 : 1'b1;
   initial begin
      cfg_wr_out = 1'b0;
      cfg_wdata_out = 16'h0000;
      temp_rd_start_out = 1'b0;
      temp_rd_out = 1'b0;
   end
   // whole word per write; data turned over once the strobe is gone
   task automatic write_cfg(input logic [`TTE_CFG_W-1:0] d);
      @(posedge sys_clk_in);
      cfg_wr_out <= 1'b1;
      cfg_wdata_out <= d;
      @(posedge sys_clk_in);
      cfg_wr_out <= 1'b0;
      cfg_wdata_out <= ~d;
   endtask : write_cfg
   // high byte first, then low byte, assembled into one word
   task automatic read_word(output logic [`TTE_WORD_W-1:0] w);
      @(posedge sys_clk_in);
      temp_rd_start_out <= 1'b1;
      temp_rd_out <= 1'b1;
      @(posedge sys_clk_in);
      temp_rd_start_out <= 1'b0;
      #1 w[15:8] = temp_byte_in;
      @(posedge sys_clk_in);
      temp_rd_out <= 1'b0;
      #1 w[7:0] = temp_byte_in;
   endtask : read_word
endmodule : tte_host_model

// file: bench/test_thermal_trip_event_logic.sv
// self-checking bench for the thermal trip event logic against a behavioural model
`timescale 1ns/1ps
`include "tte_defs.svh"
module test_thermal_trip_event_logic;
   localparam int UPPER = 400;
   localparam int LOWER = 100;
   localparam int LIMIT = 500;
   typedef struct {
      int mode, pol, conly, oen, alock, clock, shdn, hys, latch, above, below, crit, zone, temp;
   } tte_model_type;
   tte_model_type m;
   int hys_q[4] = '{0, 6, 12, 24};
   int bad_count = 0;
   int total_checks = 0;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic valid = 1'b0;
   logic [`TTE_TEMP_W-1:0] temp = 11'h000;
   logic cfg_wr, temp_rd_start, temp_rd, alert, alert_oe, alert_pin;
   logic [`TTE_CFG_W-1:0] cfg_wdata, cfg_rdata;
   logic [`TTE_BYTE_W-1:0] temp_byte;
   logic [`TTE_WORD_W-1:0] temp_word;
   always #2 sys_clk = ~sys_clk;
   tte_core i_tte_core (
      .sys_clk_in(sys_clk),
      .rst_in(rst),
      .sensing_core_valid_in(valid),
      .sensing_core_temp_in(temp),
      .upper_limit_in(16'(UPPER << 2)),
      .lower_limit_in(16'(LOWER << 2)),
      .overheat_limit_in(16'(LIMIT << 2)),
      .cfg_wr_in(cfg_wr),
      .cfg_wdata_in(cfg_wdata),
      .cfg_rdata_out(cfg_rdata),
      .temp_rd_start_in(temp_rd_start),
      .temp_rd_in(temp_rd),
      .temp_byte_out(temp_byte),
      .temp_word_out(temp_word),
      .alert_out(alert),
      .alert_oe_out(alert_oe)
   );
   tte_host_model i_tte_host_model (
      .sys_clk_in(sys_clk),
      .temp_byte_in(temp_byte),
      .alert_oe_in(alert_oe),
      .cfg_wr_out(cfg_wr),
      .cfg_wdata_out(cfg_wdata),
      .temp_rd_start_out(temp_rd_start),
      .temp_rd_out(temp_rd),
      .alert_pin_out(alert_pin)
   );
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   // let the result pass the pipeline, then compare every visible output
   task automatic settle();
      int act, w, cw, oe;
      logic [15:0] rd;
      repeat (3) @(posedge sys_clk);
      #1;
      act = m.zone | (m.mode ? m.latch : (!m.conly & (m.above | m.below)));
      w = (m.crit << 15) | (m.above << 14) | (m.below << 13) | ((m.temp & 32'h7ff) << 2);
      cw = m.mode | (m.pol << 1) | (m.conly << 2) | (m.oen << 3) | ((act & m.oen) << 4);
      cw = cw | (m.alock << 6) | (m.clock << 7) | (m.shdn << 8) | (m.hys << 9);
      oe = (act & m.oen) ^ m.pol;
      chk("temp_word", 16'(w), temp_word);
      chk("cfg_rdata", 16'(cw), cfg_rdata);
      chk("alert_oe", 16'(oe), {15'h0000, alert_oe});
      chk("alert_pin", 16'(!oe), {15'h0000, alert_pin});
      chk("alert_data", 16'h0000, {15'h0000, alert});
      i_tte_host_model.read_word(rd);
      chk("read_word", 16'(w), rd);
   endtask : settle
   task automatic cfg(input int d);
      int lk;
      lk = m.alock | m.clock;
      if (d[5] && m.mode) begin
         m.latch = 0;
      end
      if (!lk) begin
         m.mode = d[0];
         m.pol = d[1];
         m.oen = d[3];
         m.hys = d[10:9];
         m.shdn = d[8];
      end else begin
         m.shdn = m.shdn & d[8];
      end
      if (!m.alock) begin
         m.conly = d[2];
      end
      m.alock = m.alock | d[6];
      m.clock = m.clock | d[7];
      i_tte_host_model.write_cfg(16'(d));
      settle();
   endtask : cfg
   task automatic sample(input int t);
      int h, ab, be;
      @(posedge sys_clk);
      valid <= 1'b1;
      temp <= 11'(t);
      @(posedge sys_clk);
      valid <= 1'b0;
      temp <= ~11'(t);
      if (!m.shdn) begin
         h = hys_q[m.hys];
         ab = (t > UPPER) ? 1 : ((t <= UPPER - h) ? 0 : m.above);
         be = (t < LOWER - h) ? 1 : ((t >= LOWER) ? 0 : m.below);
         if (m.mode && !m.conly && ((ab && !m.above) || (be && !m.below))) begin
            m.latch = 1;
         end
         m.above = ab;
         m.below = be;
         m.crit = (t >= LIMIT);
         m.zone = (t >= LIMIT) ? 1 : ((t < LIMIT - h) ? 0 : m.zone);
         m.temp = t;
      end
      settle();
   endtask : sample
   task automatic do_reset();
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      m = '{default: 0};
   endtask : do_reset
   initial begin
      void'($urandom(49));
      do_reset();
      settle();
      // comparator style over every hysteresis code and both polarities
      for (int i = 0; i < 48; i++) begin
         if (i % 12 == 0) begin
            cfg(8 | ((i / 12) << 9) | ((i / 24) << 1));
         end
         sample(int'($urandom_range(710)) - 150);
      end
      sample(496);
      chk("temp_field", 16'h07c0, {3'h0, temp_word[12:0]});
      cfg(8);
      sample(450);
      cfg(8 | 32);
      // interrupt style from a clean start
      do_reset();
      cfg(9);
      sample(250);
      sample(420);
      sample(250);
      cfg(9 | 32);
      sample(520);
      cfg(9 | 32 | (2 << 9));
      sample(495);
      sample(480);
      cfg(16'h0402);
      sample(50);
      cfg(16'h0108);
      sample(250);
      cfg(8);
      sample(250);
      // critical-only: window trips stay silent, the critical region still alerts
      cfg(12);
      sample(450);
      sample(510);
      cfg(16'h0248);
      cfg(16'h0787);
      sample(401);
      sample(395);
      sample(394);
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      stop_test();
   end
endmodule : test_thermal_trip_event_logic
